// File: sfd_flash_end.sv
// flash end: erase, deep sleep and power-up lockout sequencing
`timescale 1ns/1ps
module sfd_flash_end
	import sfd_pkg::*;
#(
	parameter int unsigned PAGE_CLEAR_CYC      = PAGE_CLEAR_CYC_DEF,
	parameter int unsigned SECTOR_CLEAR_CYC    = SECTOR_CLEAR_CYC_DEF,
	parameter int unsigned POWERUP_LOCKOUT_CYC = LOCKOUT_CYC_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	sfd_spi_if.dev           spi,
	input  wire logic        writeProtectN,
	input  wire logic        otherCycle,
	output logic             cycleBusyFlag_q,
	output logic             writeUnlockLatch_q,
	output logic             sleeping_q,
	output logic             lockout_q,
	output logic             clearStrobe_q,
	output logic             clearSector_q,
	output logic [19:0]      clearAddr_q,
	output logic             clearDone_q
);

	// ------------------------------------------------------------
	// link domain: bit capture on the serial clock
	// ------------------------------------------------------------
	typedef enum {ST_STANDBY, ST_ERASE, ST_SLEEP_ENTER, ST_SLEEP, ST_WAKE} sfd_state_t;

	logic        inFrame_q;
	logic        frameTog_q;
	logic [5:0]  bitCnt_q;
	logic [31:0] shift_q;

	// frame flag ends with the frame's own select line
	always_ff @(posedge spi.sck or posedge spi.csn) begin
		if (spi.csn) begin
			inFrame_q <= 1'b0;
		end else begin
			inFrame_q <= 1'b1;
		end
	end

	// one toggle per frame marks that new bits exist; power-on reset gives it a known
	// start, and releasing it is safe because the host holds sck low through reset
	always_ff @(posedge spi.sck or negedge rstn) begin
		if (!rstn) begin
			frameTog_q <= 1'b0;
		end else if (!inFrame_q) begin
			frameTog_q <= ~frameTog_q;
		end
	end

	// bit count restarts on the first clock of each frame
	always_ff @(posedge spi.sck) begin
		shift_q <= {shift_q[30:0], spi.mosi};
		if (!inFrame_q) begin
			bitCnt_q <= 6'h01;
		end else if (bitCnt_q != BIT_CNT_MAX) begin
			bitCnt_q <= bitCnt_q + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// crossing into the system clock
	// ------------------------------------------------------------
	logic csnS1_q, csnS2_q, csnS3_q;
	logic togS1_q, togS2_q, togSeen_q;
	logic wpS1_q, wpS2_q;
	logic frameEnd;
	logic fresh;

	// select and protect pins are two-flop synchronised
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			csnS1_q <= 1'b1;
			csnS2_q <= 1'b1;
			csnS3_q <= 1'b1;
			togS1_q <= 1'b0;
			togS2_q <= 1'b0;
			wpS1_q  <= 1'b1;
			wpS2_q  <= 1'b1;
		end else begin
			csnS1_q <= spi.csn;
			csnS2_q <= csnS1_q;
			csnS3_q <= csnS2_q;
			togS1_q <= frameTog_q;
			togS2_q <= togS1_q;
			wpS1_q  <= writeProtectN;
			wpS2_q  <= wpS1_q;
		end
	end

	// remember which frame was already decoded
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			togSeen_q <= 1'b0;
		end else if (frameEnd) begin
			togSeen_q <= togS2_q;
		end
	end

	// shift and count are quiet once select is high, so read them here
	assign frameEnd = csnS2_q & ~csnS3_q;
	assign fresh    = frameEnd & (togS2_q != togSeen_q);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	sfd_state_t  st_q;
	logic [31:0] timer_q;
	logic [31:0] lockCnt_q;
	logic        cmd8, cmd32, standbyFree, protHit, pageSel;
	logic [7:0]  op8, op32;
	logic [19:0] addr;
	logic        eraseGo, sleepGo, wakeGo, unlockGo, lockGo;

	assign cmd8  = fresh & (bitCnt_q == OPCODE_BITS);
	assign cmd32 = fresh & (bitCnt_q == ADDR_FRAME_BITS);
	assign op8   = shift_q[7:0];
	assign op32  = shift_q[31:24];
	assign addr  = shift_q[ADDR_MSB:0];
	// sleep, wake delay and erase all block new commands
	assign standbyFree = (st_q == ST_STANDBY) & ~otherCycle;
	// bottom sector guarded while the protect pin is low
	assign protHit = ~wpS2_q & (addr[ADDR_MSB:SECTOR_LSB] == PROT_SECTOR);
	assign pageSel = (op32 == PAGE_CLEAR_CMD);

	assign eraseGo = cmd32 & standbyFree & writeUnlockLatch_q & ~lockout_q
		& ~protHit & (pageSel | (op32 == SECTOR_CLEAR_CMD));
	assign sleepGo  = cmd8 & standbyFree & (op8 == DEEP_SLEEP_CMD);
	assign unlockGo = cmd8 & standbyFree & ~lockout_q
		& (op8 == WRITE_UNLOCK_CMD);
	assign lockGo   = cmd8 & standbyFree & (op8 == WRITE_LOCK_CMD);
	// wake is the only command that leaves sleep
	assign wakeGo = cmd8 & ~otherCycle & (op8 == WAKE_FROM_SLEEP_CMD)
		& ((st_q == ST_SLEEP) | (st_q == ST_SLEEP_ENTER));

	// ------------------------------------------------------------
	// power-up write lockout
	// ------------------------------------------------------------
	// counts down from reset release on the free-running clock
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lockCnt_q <= POWERUP_LOCKOUT_CYC;
			lockout_q <= 1'b1;
		end else if (lockCnt_q != 32'h0000_0000) begin
			lockCnt_q <= lockCnt_q - 32'h0000_0001;
			lockout_q <= (lockCnt_q != 32'h0000_0001);
		end else begin
			lockout_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// mode sequencer
	// ------------------------------------------------------------
	// deselect alone never leaves standby; only an erase or sleep frame does
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q    <= ST_STANDBY;
			timer_q <= 32'h0000_0000;
		end else begin
			case (st_q)
				ST_STANDBY: begin
					if (eraseGo) begin
						st_q    <= ST_ERASE;
						timer_q <= pageSel ? PAGE_CLEAR_CYC - 1 : SECTOR_CLEAR_CYC - 1;
					end else if (sleepGo) begin
						st_q    <= ST_SLEEP_ENTER;
						timer_q <= SLEEP_ENTRY_CYC - 1;
					end
				end
				ST_ERASE: begin
					if (timer_q == 32'h0000_0000) begin
						st_q <= ST_STANDBY;
					end else begin
						timer_q <= timer_q - 32'h0000_0001;
					end
				end
				ST_SLEEP_ENTER: begin
					if (wakeGo) begin
						st_q    <= ST_WAKE;
						timer_q <= WAKE_CYC - 1;
					end else if (timer_q == 32'h0000_0000) begin
						st_q <= ST_SLEEP;
					end else begin
						timer_q <= timer_q - 32'h0000_0001;
					end
				end
				ST_SLEEP: begin
					if (wakeGo) begin
						st_q    <= ST_WAKE;
						timer_q <= WAKE_CYC - 1;
					end
				end
				ST_WAKE: begin  // frames during the wake delay are dropped
					if (timer_q == 32'h0000_0000) begin
						st_q <= ST_STANDBY;
					end else begin
						timer_q <= timer_q - 32'h0000_0001;
					end
				end
				default: begin
					st_q <= ST_STANDBY;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// latch drops at erase start, well before the cycle ends
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			writeUnlockLatch_q <= 1'b0;
		end else if (eraseGo) begin
			writeUnlockLatch_q <= 1'b0;
		end else if (unlockGo) begin
			writeUnlockLatch_q <= 1'b1;
		end else if (lockGo) begin
			writeUnlockLatch_q <= 1'b0;
		end
	end

	// busy tracks the erase state exactly
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cycleBusyFlag_q <= 1'b0;
		end else if (eraseGo) begin
			cycleBusyFlag_q <= 1'b1;
		end else if ((st_q == ST_ERASE) && (timer_q == 32'h0000_0000)) begin
			cycleBusyFlag_q <= 1'b0;
		end
	end

	// sleep seen from entry delay end until wake delay end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sleeping_q <= 1'b0;
		end else if ((st_q == ST_SLEEP_ENTER) && !wakeGo && (timer_q == 32'h0000_0000)) begin
			sleeping_q <= 1'b1;
		end else if ((st_q == ST_WAKE) && (timer_q == 32'h0000_0000)) begin
			sleeping_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// array clear requests
	// ------------------------------------------------------------
	// the array itself lives outside; it fills the region with ones
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			clearStrobe_q <= 1'b0;
			clearSector_q <= 1'b0;
			clearAddr_q   <= 20'h00000;
			clearDone_q   <= 1'b0;
		end else begin
			clearStrobe_q <= eraseGo;
			clearDone_q   <= (st_q == ST_ERASE) && (timer_q == 32'h0000_0000);
			if (eraseGo) begin
				clearSector_q <= ~pageSel;
				if (pageSel) begin
					clearAddr_q <= {addr[ADDR_MSB:PAGE_LSB], 8'h00};
				end else begin
					clearAddr_q <= {addr[ADDR_MSB:SECTOR_LSB], 16'h0000};
				end
			end
		end
	end

endmodule

// File: sfd_pkg.sv
// shared constants of the serial flash erase and deep sleep ends
package sfd_pkg;

	// ------------------------------------------------------------
	// command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] WRITE_UNLOCK_CMD  = 8'h06;
	localparam logic [7:0] WRITE_LOCK_CMD    = 8'h04;
	localparam logic [7:0] PAGE_CLEAR_CMD    = 8'hDB;
	localparam logic [7:0] SECTOR_CLEAR_CMD  = 8'hD8;
	localparam logic [7:0] DEEP_SLEEP_CMD    = 8'hB9;
	localparam logic [7:0] WAKE_FROM_SLEEP_CMD = 8'hAB;

	// ------------------------------------------------------------
	// frame and address layout
	// ------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS   = 6'h08;
	localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
	localparam logic [5:0] BIT_CNT_MAX   = 6'h3F;
	localparam int         ADDR_MSB      = 19;
	localparam int         PAGE_LSB      = 8;
	localparam int         SECTOR_LSB    = 16;
	localparam logic [3:0] PROT_SECTOR   = 4'h0;

	// ------------------------------------------------------------
	// times in their own units and derived cycle counts
	// ------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ            = 25_000_000;
	localparam int unsigned CYC_PER_US            = SYS_CLK_HZ / 1_000_000;
	localparam int unsigned PAGE_CLEAR_TIME_US    = 10_000;
	localparam int unsigned SECTOR_CLEAR_TIME_US  = 1_000_000;
	localparam int unsigned SLEEP_ENTRY_DELAY_US  = 3;
	localparam int unsigned WAKE_DELAY_US         = 30;
	localparam int unsigned POWERUP_WRITE_LOCKOUT_US = 10_000;
	localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 30;
	localparam int unsigned PAGE_CLEAR_CYC_DEF    = PAGE_CLEAR_TIME_US * CYC_PER_US;
	localparam int unsigned SECTOR_CLEAR_CYC_DEF  = SECTOR_CLEAR_TIME_US * CYC_PER_US;
	localparam int unsigned SLEEP_ENTRY_CYC       = SLEEP_ENTRY_DELAY_US * CYC_PER_US;
	localparam int unsigned WAKE_CYC              = WAKE_DELAY_US * CYC_PER_US;
	localparam int unsigned LOCKOUT_CYC_DEF       = POWERUP_WRITE_LOCKOUT_US * CYC_PER_US;
	localparam int unsigned SELECT_CYC            = SUPPLY_TO_SELECT_DELAY_US * CYC_PER_US;

	// ------------------------------------------------------------
	// host link timing
	// ------------------------------------------------------------
	localparam int unsigned SCK_HALF_CYC = 2;
	localparam int unsigned GAP_CYC      = 8;

endpackage

// File: sfd_spi_if.sv
// serial link between the host controller and the flash end
`timescale 1ns/1ps
interface sfd_spi_if;
	logic csn;
	logic sck;
	logic mosi;

	modport host (
		output csn,
		output sck,
		output mosi
	);

	modport dev (
		input csn,
		input sck,
		input mosi
	);
endinterface

// File: sfd_host_end.sv
// host end: frames commands onto the serial link from sys_clk
`timescale 1ns/1ps
module sfd_host_end
	import sfd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	sfd_spi_if.host          spi,
	input  wire logic        reqValid,
	input  wire logic [7:0]  reqOpcode,
	input  wire logic [23:0] reqAddr,
	input  wire logic [5:0]  reqBits,
	output logic             reqReady_q,
	output logic             reqDrop_q,
	output logic             frameDone_q,
	output logic             hostSleep_q
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum {H_POWER, H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP} sfd_hstate_t;

	sfd_hstate_t st_q;
	logic [15:0] timer_q;
	logic [31:0] word_q;
	logic [5:0]  bitsLeft_q;
	logic        wakeFrame_q, sleepFrame_q;
	logic        csn_q, sck_q, mosi_q;
	logic        badReq;

	// link pins come straight from flops; clock idles low
	assign spi.csn  = csn_q;
	assign spi.sck  = sck_q;
	assign spi.mosi = mosi_q;

	// only wake may go out while the device sleeps
	assign badReq = (hostSleep_q && (reqOpcode != WAKE_FROM_SLEEP_CMD))
		|| (reqBits == 6'h00) || (reqBits > ADDR_FRAME_BITS);

	// ------------------------------------------------------------
	// frame sequencer
	// ------------------------------------------------------------
	// divider by timer: each clock half lasts a fixed count
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_q         <= H_POWER;
			timer_q      <= 16'(SELECT_CYC - 1);
			word_q       <= 32'h0000_0000;
			bitsLeft_q   <= 6'h00;
			wakeFrame_q  <= 1'b0;
			sleepFrame_q <= 1'b0;
			csn_q        <= 1'b1;
			sck_q        <= 1'b0;
			mosi_q       <= 1'b0;
			reqReady_q   <= 1'b0;
			reqDrop_q    <= 1'b0;
			frameDone_q  <= 1'b0;
			hostSleep_q  <= 1'b0;
		end else begin
			reqDrop_q   <= 1'b0;
			frameDone_q <= 1'b0;
			case (st_q)
				H_POWER: begin
					if (timer_q == 16'h0000) begin
						st_q       <= H_IDLE;
						reqReady_q <= 1'b1;
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				H_IDLE: begin
					if (reqValid && badReq) begin
						reqDrop_q <= 1'b1;
					end else if (reqValid) begin
						// opcode then address, most significant bit first
						word_q       <= {reqOpcode, reqAddr};
						bitsLeft_q   <= reqBits;
						wakeFrame_q  <= (reqOpcode == WAKE_FROM_SLEEP_CMD) && (reqBits == OPCODE_BITS);
						sleepFrame_q <= (reqOpcode == DEEP_SLEEP_CMD) && (reqBits == OPCODE_BITS);
						csn_q        <= 1'b0;
						mosi_q       <= reqOpcode[7];
						timer_q      <= 16'(SCK_HALF_CYC - 1);
						reqReady_q   <= 1'b0;
						st_q         <= H_LEAD;
					end
				end
				H_LEAD, H_LOW: begin
					if (timer_q == 16'h0000) begin
						sck_q   <= 1'b1;
						timer_q <= 16'(SCK_HALF_CYC - 1);
						st_q    <= H_HIGH;
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				H_HIGH: begin
					if (timer_q == 16'h0000) begin
						sck_q      <= 1'b0;
						timer_q    <= 16'(SCK_HALF_CYC - 1);
						bitsLeft_q <= bitsLeft_q - 6'h01;
						if (bitsLeft_q == 6'h01) begin
							st_q <= H_TAIL;
						end else begin
							word_q <= {word_q[30:0], 1'b0};
							mosi_q <= word_q[30];
							st_q   <= H_LOW;
						end
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				H_TAIL: begin
					if (timer_q == 16'h0000) begin
						csn_q       <= 1'b1;
						frameDone_q <= 1'b1;
						// after wake, select stays high through the wake delay
						timer_q <= wakeFrame_q ? 16'(WAKE_CYC - 1) : 16'(GAP_CYC - 1);
						if (wakeFrame_q) begin
							hostSleep_q <= 1'b0;
						end else if (sleepFrame_q) begin
							hostSleep_q <= 1'b1;
						end
						st_q <= H_GAP;
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				H_GAP: begin
					if (timer_q == 16'h0000) begin
						reqReady_q <= 1'b1;
						st_q       <= H_IDLE;
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				default: begin
					st_q <= H_IDLE;
				end
			endcase
		end
	end

endmodule

// File: sfd_link_props.sv
// concurrent checks on the serial link and the flash end outputs
`timescale 1ns/1ps
module sfd_link_props
	import sfd_pkg::*;
#(
	parameter int unsigned PAGE_CLEAR_CYC      = 50,
	parameter int unsigned SECTOR_CLEAR_CYC    = 100,
	parameter int unsigned POWERUP_LOCKOUT_CYC = 40
) (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        csn,
	input wire logic        sck,
	input wire logic        mosi,
	input wire logic        cycleBusyFlag_q,
	input wire logic        writeUnlockLatch_q,
	input wire logic        sleeping_q,
	input wire logic        lockout_q,
	input wire logic        clearStrobe_q,
	input wire logic        clearSector_q,
	input wire logic        clearDone_q
);
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	logic [15:0] busyCnt_q;
	logic [15:0] relCnt_q;
	logic [15:0] csnHighCnt_q;
	logic        sectorKind_q;

	// busy length, latched erase kind; counts only while busy so long idles never wrap
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			busyCnt_q <= 16'h0000;
			sectorKind_q <= 1'b0;
		end else if (clearStrobe_q) begin
			busyCnt_q <= 16'h0001;
			sectorKind_q <= clearSector_q;
		end else if (cycleBusyFlag_q) begin
			busyCnt_q <= busyCnt_q + 16'h0001;
		end
	end

	// cycles since reset release and since chip select went high
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			relCnt_q <= 16'h0000;
		end else if (relCnt_q != 16'hFFFF) begin
			relCnt_q <= relCnt_q + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn || !csn) begin
			csnHighCnt_q <= 16'h0000;
		end else if (csnHighCnt_q != 16'hFFFF) begin
			csnHighCnt_q <= csnHighCnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_sck_idle_deselect: assert property (csn |-> !sck)
		else $error("serial clock high while deselected");
	a_mosi_held_high: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("data in changed while serial clock high");
	a_erase_needs_latch: assert property (clearStrobe_q |-> $past(writeUnlockLatch_q))
		else $error("erase started without write unlock");
	a_latch_clear_start: assert property (clearStrobe_q |-> !writeUnlockLatch_q)
		else $error("latch still set at erase start");
	a_busy_from_strobe: assert property ($rose(cycleBusyFlag_q) |-> clearStrobe_q)
		else $error("busy rose without an erase start");
	a_busy_exact_len: assert property (clearDone_q |->
		!cycleBusyFlag_q && busyCnt_q == (sectorKind_q ? SECTOR_CLEAR_CYC : PAGE_CLEAR_CYC))
		else $error("erase cycle length wrong");
	a_no_erase_lockout: assert property (clearStrobe_q |-> !lockout_q)
		else $error("erase started in power-up lockout");
	a_lockout_len: assert property ($fell(lockout_q) |->
		relCnt_q >= POWERUP_LOCKOUT_CYC - 1 && relCnt_q <= POWERUP_LOCKOUT_CYC)
		else $error("lockout length wrong");
	a_no_erase_sleep: assert property (clearStrobe_q |-> !sleeping_q)
		else $error("erase started while sleeping");
	a_busy_no_sleep: assert property (cycleBusyFlag_q |-> !sleeping_q)
		else $error("sleep entered during erase");
	a_sleep_entry_wait: assert property ($rose(sleeping_q) |-> csnHighCnt_q >= SLEEP_ENTRY_CYC)
		else $error("sleep entered too early");
	a_wake_wait: assert property ($fell(sleeping_q) |-> csnHighCnt_q >= WAKE_CYC)
		else $error("wake finished too early");

	c_page: cover property (clearStrobe_q && !clearSector_q);
	c_sector: cover property (clearStrobe_q && clearSector_q);
	c_sleep: cover property ($rose(sleeping_q));
	c_wake: cover property ($fell(sleeping_q));
endmodule

// File: tb.sv
// self-checking bench joining the host end and the flash end
`timescale 1ns/1ps
module tb;
	import sfd_pkg::*;
	localparam int unsigned PG = 50;
	localparam int unsigned SC = 100;
	localparam int unsigned LK = 1000; // past host select delay, so lockout is seen

	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reqValid = 1'b0;
	logic [7:0]  reqOpcode = 8'h00;
	logic [23:0] reqAddr = 24'h000000;
	logic [5:0]  reqBits = 6'h08;
	logic        writeProtectN = 1'b0;
	logic        otherCycle = 1'b0;
	logic        reqReady_q, reqDrop_q, frameDone_q, hostSleep_q;
	logic        cycleBusyFlag_q, writeUnlockLatch_q, sleeping_q, lockout_q;
	logic        clearStrobe_q, clearSector_q, clearDone_q, lastSector;
	logic [19:0] clearAddr_q, lastAddr;
	int          strobes = 0, busyLen = 0, miscompares = 0, cmp_count = 0;

	sfd_spi_if spi ();
	sfd_host_end u_sfd_host_end (.sys_clk(sys_clk), .rstn(rstn), .spi(spi),
		.reqValid(reqValid), .reqOpcode(reqOpcode), .reqAddr(reqAddr), .reqBits(reqBits),
		.reqReady_q(reqReady_q), .reqDrop_q(reqDrop_q), .frameDone_q(frameDone_q),
		.hostSleep_q(hostSleep_q));
	sfd_flash_end #(.PAGE_CLEAR_CYC(PG), .SECTOR_CLEAR_CYC(SC), .POWERUP_LOCKOUT_CYC(LK))
	u_sfd_flash_end (.sys_clk(sys_clk), .rstn(rstn), .spi(spi),
		.writeProtectN(writeProtectN), .otherCycle(otherCycle),
		.cycleBusyFlag_q(cycleBusyFlag_q), .writeUnlockLatch_q(writeUnlockLatch_q),
		.sleeping_q(sleeping_q), .lockout_q(lockout_q), .clearStrobe_q(clearStrobe_q),
		.clearSector_q(clearSector_q), .clearAddr_q(clearAddr_q), .clearDone_q(clearDone_q));
	sfd_link_props #(.PAGE_CLEAR_CYC(PG), .SECTOR_CLEAR_CYC(SC), .POWERUP_LOCKOUT_CYC(LK))
	u_sfd_link_props (.sys_clk(sys_clk), .rstn(rstn), .csn(spi.csn), .sck(spi.sck),
		.mosi(spi.mosi), .cycleBusyFlag_q(cycleBusyFlag_q),
		.writeUnlockLatch_q(writeUnlockLatch_q), .sleeping_q(sleeping_q),
		.lockout_q(lockout_q), .clearStrobe_q(clearStrobe_q),
		.clearSector_q(clearSector_q), .clearDone_q(clearDone_q));

	// ------------------------------------------------------------
	// clock, monitor and tasks
	// ------------------------------------------------------------
	always #20 sys_clk = ~sys_clk;

	// record erase starts and count busy cycles of the last one
	always @(posedge sys_clk) begin
		if (clearStrobe_q === 1'b1) begin
			strobes <= strobes + 1;
			lastAddr <= clearAddr_q;
			lastSector <= clearSector_q;
		end
		busyLen <= (clearStrobe_q === 1'b1) ? 1 : busyLen + (cycleBusyFlag_q === 1'b1);
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic timeout(input string what);
		miscompares++;
		$display("CHECK FAILED at %0t: timeout waiting for %s", $time, what);
		summarize();
	endtask
	task automatic check1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic checkNum(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitCyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// one request through the host end, back when its frame has closed
	task automatic send(input logic [7:0] op, input logic [23:0] ad, input logic [5:0] nb);
		int i;
		i = 0;
		@(negedge sys_clk);
		while (reqReady_q !== 1'b1) begin
			@(negedge sys_clk);
			i++;
			if (i > 2000) timeout("ready");
		end
		reqOpcode = op;
		reqAddr = ad;
		reqBits = nb;
		reqValid = 1'b1;
		@(negedge sys_clk);
		reqValid = 1'b0;
		i = 0;
		while (frameDone_q !== 1'b1) begin
			@(negedge sys_clk);
			i++;
			if (i > 400) timeout("frame");
		end
	endtask
	// sel 1 waits on sleeping, sel 0 on busy
	task automatic waitSig(input logic sel, input logic want);
		int i;
		i = 0;
		while ((sel ? sleeping_q : cycleBusyFlag_q) !== want) begin
			@(negedge sys_clk);
			i++;
			if (i > 1200) timeout("flag");
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		waitCyc(8);
		rstn = 1'b1;
		@(negedge sys_clk);
		check1(lockout_q, 1'b1);
		check1(cycleBusyFlag_q, 1'b0);
		check1(writeUnlockLatch_q, 1'b0);
		check1(sleeping_q, 1'b0);
		send(WRITE_UNLOCK_CMD, 24'h000000, 6'h08);
		waitCyc(8);
		check1(lockout_q, 1'b1);
		check1(writeUnlockLatch_q, 1'b0);
		waitCyc(300);
		send(PAGE_CLEAR_CMD, 24'h012345, 6'h20);
		waitCyc(8);
		checkNum(strobes, 20'h00000);
		send(WRITE_UNLOCK_CMD, 24'h000000, 6'h08);
		waitCyc(8);
		check1(writeUnlockLatch_q, 1'b1);
		send(PAGE_CLEAR_CMD, 24'hF12345, 6'h1F);
		waitCyc(8);
		checkNum(strobes, 20'h00000);
		send(PAGE_CLEAR_CMD, 24'h00FF00, 6'h20);
		waitCyc(8);
		checkNum(strobes, 20'h00000);
		send(SECTOR_CLEAR_CMD, 24'h20FFFF, 6'h20);
		waitCyc(8);
		checkNum(strobes, 20'h00000);
		check1(writeUnlockLatch_q, 1'b1);
		send(PAGE_CLEAR_CMD, 24'hF12345, 6'h20);
		waitCyc(8);
		checkNum(strobes, 20'h00001);
		checkNum(lastAddr, 20'h12300);
		check1(lastSector, 1'b0);
		check1(cycleBusyFlag_q, 1'b1);
		check1(writeUnlockLatch_q, 1'b0);
		waitSig(1'b0, 1'b0);
		checkNum(busyLen, PG);
		writeProtectN = 1'b1;
		send(WRITE_UNLOCK_CMD, 24'h000000, 6'h08);
		send(SECTOR_CLEAR_CMD, 24'h5A1234, 6'h20);
		waitCyc(8);
		checkNum(lastAddr, 20'hA0000);
		check1(lastSector, 1'b1);
		send(WRITE_UNLOCK_CMD, 24'h000000, 6'h08);
		waitCyc(8);
		check1(cycleBusyFlag_q, 1'b1);
		waitSig(1'b0, 1'b0);
		checkNum(busyLen, SC);
		check1(writeUnlockLatch_q, 1'b0);
		send(DEEP_SLEEP_CMD, 24'h000000, 6'h08);
		waitSig(1'b1, 1'b1);
		check1(sleeping_q, 1'b1);
		check1(hostSleep_q, 1'b1);
		// a non-wake request while asleep is refused at the host end
		reqOpcode = PAGE_CLEAR_CMD;
		reqBits = 6'h20;
		reqValid = 1'b1;
		@(negedge sys_clk);
		reqValid = 1'b0;
		check1(reqDrop_q, 1'b1);
		check1(reqReady_q, 1'b1);
		check1(sleeping_q, 1'b1);
		send(WAKE_FROM_SLEEP_CMD, 24'h800000, 6'h09);
		waitCyc(800);
		check1(sleeping_q, 1'b1);
		send(WAKE_FROM_SLEEP_CMD, 24'h000000, 6'h08);
		waitSig(1'b1, 1'b0);
		check1(sleeping_q, 1'b0);
		check1(hostSleep_q, 1'b0);
		send(DEEP_SLEEP_CMD, 24'h000000, 6'h07);
		waitCyc(150);
		check1(sleeping_q, 1'b0);
		otherCycle = 1'b1;
		send(WRITE_UNLOCK_CMD, 24'h000000, 6'h08);
		waitCyc(8);
		check1(writeUnlockLatch_q, 1'b0);
		otherCycle = 1'b0;
		summarize();
	end
endmodule
